// file: hw/bcs_pkg.sv
package bcs_pkg;
  // ************************************************************
  // Register byte offsets
  // ************************************************************
  localparam logic [7:0] ADDR_EN_SET     = 8'h00;
  localparam logic [7:0] ADDR_EN_CLR     = 8'h04;
  localparam logic [7:0] ADDR_VTERM      = 8'h08;
  localparam logic [7:0] ADDR_VTERM_WARM = 8'h0C;
  localparam logic [7:0] ADDR_ISET_UP    = 8'h10;
  localparam logic [7:0] ADDR_ISET_LO    = 8'h14;
  localparam logic [7:0] ADDR_TRK_SEL    = 8'h18;
  localparam logic [7:0] ADDR_ITERM_SEL  = 8'h1C;
  localparam logic [7:0] ADDR_NTC_TYPE   = 8'h20;
  localparam logic [7:0] ADDR_DISABLE    = 8'h24;
  localparam logic [7:0] ADDR_CONFIG     = 8'h28;
  localparam logic [7:0] ADDR_THR_COLD   = 8'h2C;
  localparam logic [7:0] ADDR_THR_COOL   = 8'h30;
  localparam logic [7:0] ADDR_THR_WARM   = 8'h34;
  localparam logic [7:0] ADDR_THR_HOT    = 8'h38;
  localparam logic [7:0] ADDR_RES_UP     = 8'h3C;
  localparam logic [7:0] ADDR_RES_LO     = 8'h40;
  localparam logic [7:0] ADDR_STATUS     = 8'h44;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int CFG_WARM_PAUSE_BIT = 0;
  localparam int CFG_COOL_FULL_BIT  = 1;
  localparam int DIS_NTC_BIT        = 0;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [3:0] RST_VTERM   = 4'h0;
  localparam logic [7:0] RST_ISET_UP = 8'h08;
  localparam logic       RST_ISET_LO = 1'b0;
  localparam logic [9:0] RST_COLD    = 10'h2ED;
  localparam logic [9:0] RST_COOL    = 10'h292;
  localparam logic [9:0] RST_WARM    = 10'h151;
  localparam logic [9:0] RST_HOT     = 10'h0ED;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_HZ         = 25000000;
  localparam int SAMPLE_MS      = 100;
  localparam int SAMPLE_CYC     = (CLK_HZ / 1000) * SAMPLE_MS;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_DETECT  = 3'b001,
    ST_TRICKLE = 3'b010,
    ST_CC      = 3'b011,
    ST_CV      = 3'b100,
    ST_DONE    = 3'b101
  } bcs_state_t;

  typedef enum logic [2:0] {
    RG_COLD    = 3'b000,
    RG_COOL    = 3'b001,
    RG_NOMINAL = 3'b010,
    RG_WARM    = 3'b011,
    RG_HOT     = 3'b100
  } bcs_region_t;
endpackage : bcs_pkg

// file: hw/bcs_top.sv
// What this block does
// RL1 - Enable set register starts charging with VBUS
// RL2 - Detected battery trickles, then constant current
// RL3 - Termination voltage enters CV; low current completes
// RL4 - Enable clear register stops charging
// RL5 - Full battery leaves trickle and CC promptly
// RL6 - Detection runs first; no charge before battery
// RL7 - Battery detected status bit readable
// RL8 - Reset clears all charging control bits
// RL9 - Separate normal and warm termination voltages
// RL10 - Current 32 to 800 mA, default 32
// RL11 - New current applied at next enable
// RL12 - Current code split upper and lower registers
// RL13 - Trickle uses tenth current, threshold selectable
// RL14 - Termination current 10 or 20 percent, CV only
// RL15 - Host selects one thermistor type first
// RL16 - Temperature monitoring can be disabled
// RL17 - Thresholds ordered; equal values remove regions
// RL18 - Stop cold and hot; optional warm pause
// RL19 - Threshold codes default to JEITA values
// RL20 - Cool halves current; warm uses alternate voltage
// RL21 - Periodic temperature sample kept in registers
// RL22 - Events crossing warm, hot, cool, cold
// RL23 - Higher code means colder temperature
//
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/100ps
module bcs_top #(
  parameter int SAMPLE_CYCLES = bcs_pkg::SAMPLE_CYC
) (
  input  wire logic        sys_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        vbus_present_i,
  input  wire logic        batt_present_i,
  input  wire logic        vbat_above_trickle_i,
  input  wire logic        vbat_at_term_i,
  input  wire logic        ibat_below_term_i,
  input  wire logic        temp_valid_i,
  input  wire logic [9:0]  temp_code_i,
  output logic             detect_req_o,
  output logic             charge_on_o,
  output logic             cv_mode_o,
  output logic      [8:0]  current_code_o,
  output logic      [8:0]  term_current_o,
  output logic      [3:0]  vterm_code_o,
  output logic             trickle_sel_o,
  output logic      [1:0]  ntc_type_o,
  output logic             temp_sample_req_o,
  output logic      [3:0]  temp_event_o
);

  // ************************************************************
  // Registers
  // ************************************************************
  logic                enable_r;
  logic [3:0]          vterm_r;
  logic [3:0]          vterm_warm_r;
  logic [7:0]          iset_up_r;
  logic                iset_lo_r;
  logic                trk_sel_r;
  logic                iterm_sel_r;
  logic [1:0]          ntc_type_r;
  logic                ntc_dis_r;
  logic [1:0]          config_r;
  logic [9:0]          thr_cold_r;
  logic [9:0]          thr_cool_r;
  logic [9:0]          thr_warm_r;
  logic [9:0]          thr_hot_r;
  logic [9:0]          result_r;
  logic                batt_det_r;
  logic [8:0]          ichg_r;
  bcs_pkg::bcs_state_t  state_r;
  bcs_pkg::bcs_state_t  state_nxt;
  bcs_pkg::bcs_region_t region_r;
  bcs_pkg::bcs_region_t region_nxt;
  logic [31:0]         sample_cnt_r;
  logic [31:0]         rdata_nxt;
  logic                map_hit;
  logic                wr_en;
  logic                rd_en;
  logic                charging;
  logic                temp_stop;
  logic [8:0]          icmd_nxt;

  assign wr_en    = psel_i & penable_i & pready_o & pwrite_i;
  assign rd_en    = psel_i & penable_i & ~pready_o;
  assign charging = (state_r == bcs_pkg::ST_TRICKLE) || (state_r == bcs_pkg::ST_CC)
                    || (state_r == bcs_pkg::ST_CV);

  // ************************************************************
  // APB handshake
  // ************************************************************
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end else begin
      pready_o  <= rd_en;
      pslverr_o <= rd_en & ~map_hit;
      if (rd_en && !pwrite_i) begin
        prdata_o <= rdata_nxt;
      end
    end
  end

  always_comb begin
    map_hit   = 1'b1;
    rdata_nxt = 32'h0000_0000;
    unique case (paddr_i)
      bcs_pkg::ADDR_EN_SET,
      bcs_pkg::ADDR_EN_CLR:     rdata_nxt[0] = enable_r;
      bcs_pkg::ADDR_VTERM:      rdata_nxt[3:0] = vterm_r;
      bcs_pkg::ADDR_VTERM_WARM: rdata_nxt[3:0] = vterm_warm_r;
      bcs_pkg::ADDR_ISET_UP:    rdata_nxt[7:0] = iset_up_r;
      bcs_pkg::ADDR_ISET_LO:    rdata_nxt[0] = iset_lo_r;
      bcs_pkg::ADDR_TRK_SEL:    rdata_nxt[0] = trk_sel_r;
      bcs_pkg::ADDR_ITERM_SEL:  rdata_nxt[0] = iterm_sel_r;
      bcs_pkg::ADDR_NTC_TYPE:   rdata_nxt[1:0] = ntc_type_r;
      bcs_pkg::ADDR_DISABLE:    rdata_nxt[0] = ntc_dis_r;
      bcs_pkg::ADDR_CONFIG:     rdata_nxt[1:0] = config_r;
      bcs_pkg::ADDR_THR_COLD:   rdata_nxt[9:0] = thr_cold_r;
      bcs_pkg::ADDR_THR_COOL:   rdata_nxt[9:0] = thr_cool_r;
      bcs_pkg::ADDR_THR_WARM:   rdata_nxt[9:0] = thr_warm_r;
      bcs_pkg::ADDR_THR_HOT:    rdata_nxt[9:0] = thr_hot_r;
      // RL21 result readback
      bcs_pkg::ADDR_RES_UP:     rdata_nxt[7:0] = result_r[9:2];
      bcs_pkg::ADDR_RES_LO:     rdata_nxt[1:0] = result_r[1:0];
      // RL7 detected bit
      bcs_pkg::ADDR_STATUS:     rdata_nxt[7:0] = {region_r, state_r, batt_det_r, enable_r};
      default:                  map_hit = 1'b0;
    endcase
  end

  // ************************************************************
  // Enable control
  // ************************************************************
  always_ff @(posedge sys_clk_i) begin
    // RL8 reset disables
    if (sys_rst_i) begin
      enable_r <= 1'b0;
    end else if (wr_en && paddr_i == bcs_pkg::ADDR_EN_SET && pwdata_i[0]) begin
      // RL1 enable set
      enable_r <= 1'b1;
    end else if (wr_en && paddr_i == bcs_pkg::ADDR_EN_CLR && pwdata_i[0]) begin
      // RL4 enable clear
      enable_r <= 1'b0;
    end
  end

  // ************************************************************
  // Configuration registers
  // ************************************************************
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      vterm_r      <= bcs_pkg::RST_VTERM;
      vterm_warm_r <= bcs_pkg::RST_VTERM;
      // RL10 default minimum
      iset_up_r    <= bcs_pkg::RST_ISET_UP;
      iset_lo_r    <= bcs_pkg::RST_ISET_LO;
      trk_sel_r    <= 1'b0;
      iterm_sel_r  <= 1'b0;
      ntc_type_r   <= 2'h0;
      ntc_dis_r    <= 1'b0;
      config_r     <= 2'h0;
      // RL19 JEITA defaults
      thr_cold_r   <= bcs_pkg::RST_COLD;
      thr_cool_r   <= bcs_pkg::RST_COOL;
      thr_warm_r   <= bcs_pkg::RST_WARM;
      thr_hot_r    <= bcs_pkg::RST_HOT;
    end else if (wr_en) begin
      unique case (paddr_i)
        // RL9 two voltages
        bcs_pkg::ADDR_VTERM:      vterm_r <= pwdata_i[3:0];
        bcs_pkg::ADDR_VTERM_WARM: vterm_warm_r <= pwdata_i[3:0];
        // RL12 split code
        bcs_pkg::ADDR_ISET_UP:    iset_up_r <= pwdata_i[7:0];
        bcs_pkg::ADDR_ISET_LO:    iset_lo_r <= pwdata_i[0];
        bcs_pkg::ADDR_TRK_SEL:    trk_sel_r <= pwdata_i[0];
        bcs_pkg::ADDR_ITERM_SEL:  iterm_sel_r <= pwdata_i[0];
        bcs_pkg::ADDR_NTC_TYPE:   ntc_type_r <= pwdata_i[1:0];
        // RL16 monitor disable
        bcs_pkg::ADDR_DISABLE:    ntc_dis_r <= pwdata_i[bcs_pkg::DIS_NTC_BIT];
        bcs_pkg::ADDR_CONFIG:     config_r <= pwdata_i[1:0];
        // RL17 any order stored
        bcs_pkg::ADDR_THR_COLD:   thr_cold_r <= pwdata_i[9:0];
        bcs_pkg::ADDR_THR_COOL:   thr_cool_r <= pwdata_i[9:0];
        bcs_pkg::ADDR_THR_WARM:   thr_warm_r <= pwdata_i[9:0];
        bcs_pkg::ADDR_THR_HOT:    thr_hot_r <= pwdata_i[9:0];
        default:                  ;
      endcase
    end
  end

  // ************************************************************
  // Charge sequencer
  // ************************************************************
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      // RL1 needs enable and VBUS
      bcs_pkg::ST_IDLE:    if (enable_r && vbus_present_i) state_nxt = bcs_pkg::ST_DETECT;
      // RL6 wait for battery
      bcs_pkg::ST_DETECT:  if (batt_present_i) state_nxt = bcs_pkg::ST_TRICKLE;
      // RL2 RL5 trickle exit
      bcs_pkg::ST_TRICKLE: if (vbat_above_trickle_i) state_nxt = bcs_pkg::ST_CC;
      // RL3 RL5 enter CV
      bcs_pkg::ST_CC:      if (vbat_at_term_i) state_nxt = bcs_pkg::ST_CV;
      // RL14 evaluated in CV only
      bcs_pkg::ST_CV:      if (ibat_below_term_i) state_nxt = bcs_pkg::ST_DONE;
      bcs_pkg::ST_DONE:    state_nxt = bcs_pkg::ST_DONE;
      default:             state_nxt = bcs_pkg::ST_IDLE;
    endcase
    // RL4 stop on disable
    if (!enable_r || !vbus_present_i) begin
      state_nxt = bcs_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      state_r <= bcs_pkg::ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // RL11 latch on start
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      ichg_r <= {bcs_pkg::RST_ISET_UP, bcs_pkg::RST_ISET_LO};
    end else if (state_r == bcs_pkg::ST_IDLE && state_nxt == bcs_pkg::ST_DETECT) begin
      ichg_r <= {iset_up_r, iset_lo_r};
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      batt_det_r <= 1'b0;
    end else begin
      batt_det_r <= batt_present_i;
    end
  end

  // ************************************************************
  // Temperature sampling and regions
  // ************************************************************
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      sample_cnt_r      <= 32'h0000_0000;
      temp_sample_req_o <= 1'b0;
    end else if (charging && !ntc_dis_r) begin
      // RL21 periodic sample
      temp_sample_req_o <= (sample_cnt_r == 32'h0000_0000);
      if (sample_cnt_r >= 32'(SAMPLE_CYCLES - 1)) begin
        sample_cnt_r <= 32'h0000_0000;
      end else begin
        sample_cnt_r <= sample_cnt_r + 32'h0000_0001;
      end
    end else begin
      sample_cnt_r      <= 32'h0000_0000;
      temp_sample_req_o <= 1'b0;
    end
  end

  always_comb begin
    // RL23 higher code is colder
    if (temp_code_i > thr_cold_r) begin
      region_nxt = bcs_pkg::RG_COLD;
    end else if (temp_code_i > thr_cool_r) begin
      region_nxt = bcs_pkg::RG_COOL;
    end else if (temp_code_i < thr_hot_r) begin
      region_nxt = bcs_pkg::RG_HOT;
    end else if (temp_code_i < thr_warm_r) begin
      region_nxt = bcs_pkg::RG_WARM;
    end else begin
      region_nxt = bcs_pkg::RG_NOMINAL;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      result_r     <= 10'h000;
      region_r     <= bcs_pkg::RG_NOMINAL;
      temp_event_o <= 4'h0;
    end else if (ntc_dis_r) begin
      region_r     <= bcs_pkg::RG_NOMINAL;
      temp_event_o <= 4'h0;
    end else if (temp_valid_i) begin
      result_r     <= temp_code_i;
      region_r     <= region_nxt;
      // RL22 crossing events
      temp_event_o <= {region_r < bcs_pkg::RG_WARM && region_nxt >= bcs_pkg::RG_WARM,
                       region_r < bcs_pkg::RG_HOT && region_nxt == bcs_pkg::RG_HOT,
                       region_r > bcs_pkg::RG_COOL && region_nxt <= bcs_pkg::RG_COOL,
                       region_r > bcs_pkg::RG_COLD && region_nxt == bcs_pkg::RG_COLD};
    end else begin
      temp_event_o <= 4'h0;
    end
  end

  // ************************************************************
  // Analog setpoints
  // ************************************************************
  // RL18 cold hot and optional warm stop
  assign temp_stop = (region_r == bcs_pkg::RG_COLD) || (region_r == bcs_pkg::RG_HOT)
                     || (config_r[bcs_pkg::CFG_WARM_PAUSE_BIT]
                         && region_r == bcs_pkg::RG_WARM);

  always_comb begin
    icmd_nxt = ichg_r;
    if (state_r == bcs_pkg::ST_TRICKLE) begin
      // RL13 tenth of current
      icmd_nxt = 9'(ichg_r / 9'd10);
    end else if (region_r == bcs_pkg::RG_COOL && !config_r[bcs_pkg::CFG_COOL_FULL_BIT]) begin
      // RL20 half in cool
      icmd_nxt = {1'b0, ichg_r[8:1]};
    end
    if (!charging || temp_stop) begin
      icmd_nxt = 9'h000;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      detect_req_o   <= 1'b0;
      charge_on_o    <= 1'b0;
      cv_mode_o      <= 1'b0;
      current_code_o <= 9'h000;
      term_current_o <= 9'h000;
      vterm_code_o   <= bcs_pkg::RST_VTERM;
      trickle_sel_o  <= 1'b0;
      ntc_type_o     <= 2'h0;
    end else begin
      // RL6 detection on start
      detect_req_o   <= (state_r == bcs_pkg::ST_DETECT);
      charge_on_o    <= charging && !temp_stop;
      cv_mode_o      <= (state_r == bcs_pkg::ST_CV);
      current_code_o <= icmd_nxt;
      // RL14 10 or 20 percent
      term_current_o <= iterm_sel_r ? 9'(ichg_r / 9'd5) : 9'(ichg_r / 9'd10);
      // RL20 warm alternate voltage
      vterm_code_o   <= (region_r == bcs_pkg::RG_WARM) ? vterm_warm_r : vterm_r;
      trickle_sel_o  <= trk_sel_r;
      // RL15 type forwarded
      ntc_type_o     <= ntc_type_r;
    end
  end

endmodule : bcs_top

// file: test/bcs_top_assertions.sv
`timescale 1ns/100ps
module bcs_top_assertions #(
  parameter int SAMPLE_CYCLES = 20
) (
  input wire logic       sys_clk_i,
  input wire logic       sys_rst_i,
  input wire logic       psel_i,
  input wire logic       penable_i,
  input wire logic [7:0] paddr_i,
  input wire logic       pready_o,
  input wire logic       pslverr_o,
  input wire logic       vbus_present_i,
  input wire logic       vbat_above_trickle_i,
  input wire logic       vbat_at_term_i,
  input wire logic       ibat_below_term_i,
  input wire logic       temp_valid_i,
  input wire logic       detect_req_o,
  input wire logic       charge_on_o,
  input wire logic       cv_mode_o,
  input wire logic [8:0] current_code_o,
  input wire logic       temp_sample_req_o,
  input wire logic [3:0] temp_event_o
);
  int   gap_r;
  logic seen_r;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  // ****
  // Sample spacing
  // ****
  always_ff @(posedge sys_clk_i) begin
    gap_r <= (sys_rst_i || temp_sample_req_o) ? 0 : gap_r + 1;
  end
  // A new charge cycle restarts the sample period, so spacing history ends at detection
  always_ff @(posedge sys_clk_i) begin
    seen_r <= (sys_rst_i || detect_req_o) ? 1'b0 : (seen_r || temp_sample_req_o);
  end
  sequence s_access;
    psel_i && penable_i && !pready_o;
  endsequence
  sequence s_full_start;
    $rose(charge_on_o) && $fell(detect_req_o) && vbat_above_trickle_i && vbat_at_term_i;
  endsequence
  // ****
  // Properties
  // ****
  a_pready_next: assert property (s_access |=> pready_o)
    else $error("no ready after access");
  a_err_unmapped: assert property (s_access ##0 (paddr_i > 8'h44) |=> pslverr_o)
    else $error("unmapped access not refused");
  a_reset_clear: assert property (disable iff (1'b0)
    sys_rst_i |=> !charge_on_o && !detect_req_o && !cv_mode_o && current_code_o == 9'h000)
    else $error("outputs not cleared by reset");
  a_vbus_stop: assert property (!vbus_present_i |-> ##2 !charge_on_o && !cv_mode_o)
    else $error("charging without input supply");
  a_detect_first: assert property (detect_req_o |-> !charge_on_o)
    else $error("charging during detection");
  a_full_batt: assert property (s_full_start |-> ##[1:4] (cv_mode_o || !charge_on_o))
    else $error("full battery not moved on");
  a_cv_done: assert property (cv_mode_o && ibat_below_term_i |-> ##2 !cv_mode_o)
    else $error("no completion at low current");
  a_idle_zero: assert property (!charge_on_o |-> current_code_o == 9'h000)
    else $error("current while not charging");
  a_event_cause: assert property (temp_event_o != 4'h0 |-> $past(temp_valid_i))
    else $error("event without sample");
  a_sample_gap: assert property (temp_sample_req_o && seen_r |-> gap_r >= SAMPLE_CYCLES - 1)
    else $error("samples too close");
endmodule : bcs_top_assertions

// file: test/bcs_battery_model.sv
`timescale 1ns/100ps
module bcs_battery_model (
  input  wire logic       sys_clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       fitted_i,
  input  wire logic [1:0] stage_i,
  input  wire logic [9:0] temp_i,
  input  wire logic       cv_mode_i,
  input  wire logic       temp_sample_req_i,
  output logic            batt_present_o,
  output logic            vbat_above_trickle_o,
  output logic            vbat_at_term_o,
  output logic            ibat_below_term_o,
  output logic            temp_valid_o,
  output logic      [9:0] temp_code_o
);
  logic [2:0] dly_r;
  // ****
  // Cell voltage and current
  // ****
  always_ff @(posedge sys_clk_i) begin
    batt_present_o       <= fitted_i;
    vbat_above_trickle_o <= fitted_i && stage_i >= 2'h1;
    vbat_at_term_o       <= fitted_i && stage_i >= 2'h2;
    ibat_below_term_o    <= cv_mode_i && stage_i == 2'h3;
  end
  // ****
  // Thermistor conversion
  // ****
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      dly_r        <= 3'h0;
      temp_valid_o <= 1'b0;
      temp_code_o  <= 10'h000;
    end else begin
      dly_r        <= temp_sample_req_i ? 3'h3 : dly_r - 3'(dly_r != 3'h0);
      temp_valid_o <= dly_r == 3'h1;
      // code falls warmer; line toggles when idle
      temp_code_o  <= (dly_r == 3'h1) ? temp_i : ~temp_code_o;
    end
  end
endmodule : bcs_battery_model

// file: test/test_bcs_top.sv
`timescale 1ns/100ps
`define CHK(g, x) begin comparisons++; if ((g) !== (x)) begin num_errors++; $display("ERROR t=%0t got=%h exp=%h", $time, g, x); end end
module test_bcs_top;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, vbus, fitted, err;
  logic        bpres, vtrk, vterm, ibelow, tvalid, detect, chg, cv, treq, trk;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic [9:0]  tcode, temp;
  logic [8:0]  cur, iterm;
  logic [3:0]  vt, ev, evs;
  logic [1:0]  stage, ntc;
  int          num_errors, comparisons, c, cn, m[int];
  int          rv[18] = '{0, 0, 0, 0, 8, 0, 0, 0, 0, 0, 0, 10'h2ED, 10'h292, 10'h151, 10'h0ED, 0, 0, 8'h40};
  int          tc[8] = '{700, 500, 760, 500, 300, 500, 200, 500};
  int          tr[8] = '{1, 2, 0, 2, 3, 2, 4, 2};
  int          te[8] = '{2, 0, 3, 0, 8, 0, 12, 0};
  bcs_top #(.SAMPLE_CYCLES(20)) bcs_top_inst (
    .sys_clk_i(clk), .sys_rst_i(rst), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .vbus_present_i(vbus), .batt_present_i(bpres),
    .vbat_above_trickle_i(vtrk), .vbat_at_term_i(vterm), .ibat_below_term_i(ibelow),
    .temp_valid_i(tvalid), .temp_code_i(tcode), .detect_req_o(detect), .charge_on_o(chg),
    .cv_mode_o(cv), .current_code_o(cur), .term_current_o(iterm), .vterm_code_o(vt),
    .trickle_sel_o(trk), .ntc_type_o(ntc), .temp_sample_req_o(treq), .temp_event_o(ev));
  bcs_battery_model bcs_battery_model_inst (
    .sys_clk_i(clk), .sys_rst_i(rst), .fitted_i(fitted), .stage_i(stage), .temp_i(temp),
    .cv_mode_i(cv), .temp_sample_req_i(treq), .batt_present_o(bpres),
    .vbat_above_trickle_o(vtrk), .vbat_at_term_o(vterm), .ibat_below_term_o(ibelow),
    .temp_valid_o(tvalid), .temp_code_o(tcode));
  always #20 clk = ~clk;
  always @(posedge clk) if (ev !== 4'h0) evs <= evs | ev;
  // ****
  // Bus and reference tasks
  // ****
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) num_errors++;
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input int d);
    apb(1'b1, a, d);
    m[a] = d;
  endtask : wr
  task automatic wst(input int s);
    int n;
    n = 0;
    do begin
      apb(1'b0, 8'h44, 0);
      n++;
    end while (q[4:2] !== s[2:0] && n < 30);
    `CHK(q[4:2], s[2:0])
  endtask : wst
  task automatic tstep(input int code, input int rg, input int xev, input int cfg);
    int n;
    int e;
    temp <= code[9:0];
    evs = 4'h0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!(tvalid === 1'b1 && tcode === code[9:0]) && n < 80);
    repeat (3) @(posedge clk);
    e = (rg == 0 || rg == 4 || (rg == 3 && cfg[0])) ? 0 : (rg == 1 && !cfg[1]) ? c / 2 : c;
    `CHK(evs, xev[3:0])
    `CHK(cur, e[8:0])
    `CHK(chg, e != 0)
    if (rg > 0 && rg < 4) `CHK(vt, m[rg == 3 ? 8'h0C : 8'h08])
    apb(1'b0, 8'h44, 0);
    `CHK(q[7:5], rg[2:0])
    apb(1'b0, 8'h3C, 0);
    `CHK(q, code >> 2)
    apb(1'b0, 8'h40, 0);
    `CHK(q, code & 3)
  endtask : tstep
  task automatic tally_and_finish;
    if (num_errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish
  // ****
  // Scenarios
  // ****
  initial begin
    {clk, psel, penable, pwrite, fitted, paddr, pwdata, stage, evs} = '0;
    {rst, vbus} = 2'b11;
    temp = 10'h1F4;
    num_errors = 0;
    comparisons = 0;
    void'($urandom(42963));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 18; i++) begin
      m[i * 4] = rv[i];
      apb(1'b0, 8'(i * 4), 0);
      `CHK(q, rv[i])
    end
    apb(1'b0, 8'h48, 0);
    `CHK({err, q}, 33'h100000000)
    for (int i = 2; i < 11; i++) begin
      if (i != 4 && i != 9) wr(8'(i * 4), (i == 8) ? $urandom % 3 : $urandom & 8'hFF);
    end
    c = 16 + $urandom % 385;
    wr(8'h10, c >> 1);
    wr(8'h14, c & 1);
    for (int i = 2; i < 11; i++) begin
      apb(1'b0, 8'(i * 4), 0);
      `CHK(q, m[i * 4] & ((i == 4) ? 255 : (i < 4) ? 15 : (i == 8 || i == 10) ? 3 : 1))
    end
    `CHK({trk, ntc}, {m[8'h18][0], m[8'h20][1:0]})
    m[8'h28] = 0;
    m[8'h08] &= 15;
    m[8'h0C] &= 15;
    wr(8'h28, 0);
    apb(1'b1, 8'h00, 1);
    wst(1);
    `CHK({detect, chg, q[1:0]}, 4'b1001)
    fitted <= 1'b1;
    wst(2);
    `CHK(cur, 9'(c / 10))
    stage <= 2'h1;
    wst(3);
    `CHK(cur, c[8:0])
    `CHK(iterm, 9'(m[8'h1C][0] ? c / 5 : c / 10))
    `CHK(vt, m[8'h08])
    cn = 16 + $urandom % 385;
    wr(8'h10, cn >> 1);
    wr(8'h14, cn & 1);
    `CHK(cur, c[8:0])
    stage <= 2'h2;
    wst(4);
    `CHK(cv, 1'b1)
    stage <= 2'h3;
    wst(5);
    `CHK(chg, 1'b0)
    apb(1'b1, 8'h04, 1);
    wst(0);
    `CHK({q[0], cur}, 10'h000)
    stage <= 2'h1;
    c = cn;
    apb(1'b1, 8'h00, 1);
    wst(3);
    `CHK(cur, c[8:0])
    for (int k = 0; k < 4; k += 3) begin
      wr(8'h28, k);
      for (int i = 0; i < 8; i++) tstep(tc[i], tr[i], te[i], k);
    end
    wr(8'h34, 300);
    wr(8'h38, 300);
    tstep(310, 2, 0, 3);
    tstep(290, 4, 12, 3);
    wr(8'h24, 1);
    repeat (30) @(posedge clk);
    apb(1'b0, 8'h44, 0);
    `CHK({q[7:5], treq, cur}, {3'h2, 1'b0, c[8:0]})
    `CHK(chg, 1'b1)
    wr(8'h24, 0);
    tstep(500, 2, 0, 3);
    vbus <= 1'b0;
    wst(0);
    stage <= 2'h2;
    vbus <= 1'b1;
    wst(4);
    tally_and_finish();
  end
  initial begin
    #(40 * 60000);
    num_errors++;
    tally_and_finish();
  end
endmodule : test_bcs_top
bind bcs_top bcs_top_assertions #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) bcs_top_assertions_inst (
  .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i),
  .paddr_i(paddr_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .vbus_present_i(vbus_present_i), .vbat_above_trickle_i(vbat_above_trickle_i),
  .vbat_at_term_i(vbat_at_term_i), .ibat_below_term_i(ibat_below_term_i),
  .temp_valid_i(temp_valid_i), .detect_req_o(detect_req_o), .charge_on_o(charge_on_o),
  .cv_mode_o(cv_mode_o), .current_code_o(current_code_o),
  .temp_sample_req_o(temp_sample_req_o), .temp_event_o(temp_event_o));
